/* logic/framer_regs.vh */
// register map, field positions, reset values and codes of the periodic response framer
`ifndef FRAMER_REGS_VH
`define FRAMER_REGS_VH

// ---------------------------------------------------------------
// register indices (byte address = 4 * index)
// ---------------------------------------------------------------
`define IDX_DEV_STATUS_1   8'h01
`define IDX_DEV_STATUS_2   8'h02
`define IDX_DEV_STATUS_3   8'h03
`define IDX_DEV_STATUS_4   8'h04
`define IDX_SOURCE_IDENT_A 8'h1A
`define IDX_SOURCE_IDENT_B 8'h1B
`define IDX_FRAMER_CTRL    8'h20
`define IDX_FRAMER_STAT    8'h21

// ---------------------------------------------------------------
// source_ident_reg fields
// ---------------------------------------------------------------
`define SID_FIELD_LSB      0
`define SID_FMT_LSB        4
`define SID_FMT_ID_BIT     0
`define SID_FMT_KAC_BIT    1
`define SID_FMT_ST_BIT     2
`define SID_DTYPE_BIT      7
`define SID_A_RESET        8'h71
`define SID_B_RESET        8'h72

// ---------------------------------------------------------------
// framer_ctrl fields
// ---------------------------------------------------------------
`define CTRL_PCM_EN_BIT    0
`define CTRL_SUP_SUPP_BIT  1
`define CTRL_SIGNED_A_BIT  2
`define CTRL_SIGNED_B_BIT  3
`define CTRL_RESET         8'h00

// ---------------------------------------------------------------
// field widths, crc, timing
// ---------------------------------------------------------------
`define ID_W               4
`define KAC_W              2
`define ST_W               4
`define CRC_POLY           8'h2F
`define SUP_HOLD_CYCLES    16'h0064

// ---------------------------------------------------------------
// status codes
// ---------------------------------------------------------------
`define ST_NORMAL          4'h0
`define ST_UNLOCKED        4'h1
`define ST_SELFTEST        4'h2
`define ST_OSC_TRAIN       4'h3
`define ST_ABS_PRESS       4'h4
`define ST_TEMP            4'h5
`define ST_USER_OTP        4'h8
`define ST_USER_RW         4'h9
`define ST_FACT_OTP        4'hA
`define ST_TEST_MODE       4'hB
`define ST_SUPPLY          4'hC
`define ST_RESET_ERR       4'hD

`endif

/* logic/crc8_serial.v */
// serial augmented crc-8 engine, msb first
`timescale 1ns/1ps
`default_nettype none
module crc8_serial #(
	parameter [7:0] POLY = 8'h2F
) (
	input  wire       clk_i,
	input  wire       rstn_i,
	input  wire       load_i,
	input  wire [7:0] seed_i,
	input  wire       step_i,
	input  wire       din_i,
	output wire [7:0] crc_o
);
	reg  [7:0] crc_r;
	wire [7:0] crc_nxt;

	// bit enters at the lsb, msb falling out folds the polynomial back in
	assign crc_nxt = {crc_r[6:0], din_i} ^ (crc_r[7] ? POLY : 8'h00);
	assign crc_o   = crc_r;

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			crc_r <= 8'h00;
		end else if (load_i) begin
			crc_r <= seed_i;
		end else if (step_i) begin
			crc_r <= crc_nxt;
		end
	end
endmodule
`default_nettype wire

/* logic/periodic_response_framer.v */
// periodic collection response framer with apb register file
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "framer_regs.vh"
module periodic_response_framer #(
	parameter        DATA_W        = 10,
	parameter [9:0]  ERR_UNSIGNED  = 10'h000,
	parameter [9:0]  ERR_SIGNED    = 10'h200,
	parameter [15:0] SUP_HOLD_CYC  = `SUP_HOLD_CYCLES
) (
	input  wire              clk_i,
	input  wire              rstn_i,
	input  wire              psel_i,
	input  wire              penable_i,
	input  wire              pwrite_i,
	input  wire [11:0]       paddr_i,
	input  wire [31:0]       pwdata_i,
	output reg  [31:0]       prdata_o,
	output reg               pready_o,
	output reg               pslverr_o,
	input  wire              trigger_i,
	input  wire              trigger_src_i,
	input  wire [DATA_W-1:0] meas_abs_i,
	input  wire [DATA_W-1:0] meas_rel_i,
	input  wire              supply_fault_i,
	input  wire              temp_fault_i,
	input  wire              user_otp_fault_i,
	input  wire              user_rw_fault_i,
	input  wire              fact_otp_fault_i,
	input  wire              osc_train_fault_i,
	input  wire              test_active_flag_i,
	input  wire              reset_occurred_flag_i,
	input  wire              selftest_pending_i,
	input  wire              config_unlocked_i,
	input  wire              abs_pressure_high_i,
	input  wire              abs_pressure_low_i,
	input  wire              abs_pressure_disagree_i,
	output reg               tx_bit_o,
	output reg               tx_valid_o,
	output reg               tx_last_o,
	input  wire              tx_ready_i,
	output reg               busy_o
);
	localparam FRM_W = `ID_W + `KAC_W + `ST_W + DATA_W;
	localparam ALL_W = FRM_W + 8;
	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_CALC = 3'b010;
	localparam [2:0] S_SEND = 3'b100;

	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	reg  [7:0]       dev_status_1_r;
	reg  [7:0]       dev_status_2_r;
	reg  [7:0]       dev_status_3_r;
	reg  [7:0]       dev_status_4_r;
	reg  [7:0]       source_ident_a_r;
	reg  [7:0]       source_ident_b_r;
	reg  [7:0]       ctrl_r;
	reg  [1:0]       kac_a_r;
	reg  [1:0]       kac_b_r;
	reg  [3:0]       last_code_r;
	reg  [15:0]      sup_cnt_r;
	reg              sup_expired_r;
	reg              err_pend_r;
	reg  [2:0]       state_r;
	reg              src_r;
	reg  [ALL_W-1:0] shift_r;
	reg  [4:0]       len_r;
	reg  [5:0]       cnt_r;
	reg  [5:0]       send_cnt_r;

	wire [7:0]       word_idx;
	wire             apb_access;
	wire             apb_wr;
	reg              hit;
	reg  [7:0]       rdata;

	assign word_idx   = paddr_i[9:2];
	assign apb_access = psel_i & penable_i;
	assign apb_wr     = apb_access & pready_o & pwrite_i;

	// ---------------------------------------------------------------
	// apb read decode
	// ---------------------------------------------------------------
	always @* begin
		hit   = (paddr_i[11:10] == 2'b00) && (paddr_i[1:0] == 2'b00);
		rdata = 8'h00;
		case (word_idx)
		`IDX_DEV_STATUS_1:   rdata = dev_status_1_r;
		`IDX_DEV_STATUS_2:   rdata = dev_status_2_r;
		`IDX_DEV_STATUS_3:   rdata = dev_status_3_r;
		`IDX_DEV_STATUS_4:   rdata = dev_status_4_r;
		`IDX_SOURCE_IDENT_A: rdata = source_ident_a_r;
		`IDX_SOURCE_IDENT_B: rdata = source_ident_b_r;
		`IDX_FRAMER_CTRL:    rdata = ctrl_r;
		`IDX_FRAMER_STAT:    rdata = {kac_b_r, kac_a_r, last_code_r};
		default:             hit = 1'b0;
		endcase
	end

	// one wait state keeps pready and prdata straight from flops
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end else begin
			pready_o  <= apb_access & ~pready_o;
			pslverr_o <= apb_access & ~pready_o & ~hit;
			prdata_o  <= (apb_access & ~pready_o & ~pwrite_i) ? {24'h00_0000, rdata}
			                                                   : 32'h0000_0000;
		end
	end

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			source_ident_a_r <= `SID_A_RESET;
			source_ident_b_r <= `SID_B_RESET;
			ctrl_r           <= `CTRL_RESET;
		end else if (apb_wr && hit) begin
			case (word_idx)
			`IDX_SOURCE_IDENT_A: source_ident_a_r <= pwdata_i[7:0];
			`IDX_SOURCE_IDENT_B: source_ident_b_r <= pwdata_i[7:0];
			`IDX_FRAMER_CTRL:    ctrl_r           <= pwdata_i[7:0];
			default:             ctrl_r           <= ctrl_r;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// status capture and supply monitor timer
	// ---------------------------------------------------------------
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dev_status_1_r <= 8'h00;
			dev_status_2_r <= 8'h00;
			dev_status_3_r <= 8'h00;
			dev_status_4_r <= 8'h00;
			sup_cnt_r      <= 16'h0000;
			sup_expired_r  <= 1'b0;
		end else begin
			dev_status_1_r <= {7'h00, supply_fault_i};
			dev_status_2_r <= {4'h0, fact_otp_fault_i, user_rw_fault_i,
			                   user_otp_fault_i, temp_fault_i};
			dev_status_3_r <= {7'h00, osc_train_fault_i};
			dev_status_4_r <= {1'b0, abs_pressure_disagree_i, abs_pressure_low_i,
			                   abs_pressure_high_i, config_unlocked_i, selftest_pending_i,
			                   reset_occurred_flag_i, test_active_flag_i};
			if (!dev_status_1_r[0]) begin
				sup_cnt_r     <= 16'h0000;
				sup_expired_r <= 1'b0;
			end else if (sup_cnt_r >= SUP_HOLD_CYC - 16'h0001) begin
				sup_expired_r <= 1'b1;
			end else begin
				sup_cnt_r <= sup_cnt_r + 16'h0001;
			end
		end
	end

	// ---------------------------------------------------------------
	// status ranking
	// ---------------------------------------------------------------
	wire sup_fault_w  = dev_status_1_r[0];
	wire sup_withhold = sup_fault_w & ~sup_expired_r;
	wire sup_report   = sup_fault_w & sup_expired_r & ~ctrl_r[`CTRL_SUP_SUPP_BIT];
	reg  [3:0] code;

	// first match is the smallest priority number
	always @* begin
		if (dev_status_4_r[1])
			code = `ST_RESET_ERR;
		else if (sup_report)
			code = `ST_SUPPLY;
		else if (dev_status_4_r[0])
			code = `ST_TEST_MODE;
		else if (dev_status_2_r[3])
			code = `ST_FACT_OTP;
		else if (dev_status_2_r[2])
			code = `ST_USER_RW;
		else if (dev_status_2_r[1])
			code = `ST_USER_OTP;
		else if (dev_status_2_r[0])
			code = `ST_TEMP;
		else if (|dev_status_4_r[6:4])
			code = `ST_ABS_PRESS;
		else if (dev_status_3_r[0])
			code = `ST_OSC_TRAIN;
		else if (dev_status_4_r[2])
			code = `ST_SELFTEST;
		else if (dev_status_4_r[3])
			code = `ST_UNLOCKED;
		else
			code = `ST_NORMAL;
	end

	// ---------------------------------------------------------------
	// frame assembly
	// ---------------------------------------------------------------
	wire [7:0]        sid      = trigger_src_i ? source_ident_b_r : source_ident_a_r;
	wire [2:0]        fmt      = sid[`SID_FMT_LSB+2:`SID_FMT_LSB];
	wire              id_on    = fmt[`SID_FMT_ID_BIT];
	wire              kac_on   = fmt[`SID_FMT_KAC_BIT];
	wire              st_on    = fmt[`SID_FMT_ST_BIT];
	wire [1:0]        kac_cur  = trigger_src_i ? kac_b_r : kac_a_r;
	wire              any_sign = ctrl_r[`CTRL_SIGNED_A_BIT] | ctrl_r[`CTRL_SIGNED_B_BIT];
	wire [DATA_W-1:0] err_code = any_sign ? ERR_SIGNED : ERR_UNSIGNED;
	wire [DATA_W-1:0] meas     = sid[`SID_DTYPE_BIT] ? meas_rel_i : meas_abs_i;
	// with status shown, only codes 1000 and up hide data; without it, any fault does
	wire              need_err = st_on ? code[3] : (code != `ST_NORMAL);
	wire              use_err  = need_err | err_pend_r;
	wire              pcm_en   = ctrl_r[`CTRL_PCM_EN_BIT];
	wire              launch   = trigger_i & pcm_en & state_r[0] & ~sup_withhold;
	reg  [FRM_W-1:0]  frm;
	reg  [4:0]        len;

	always @* begin
		frm = {FRM_W{1'b0}};
		len = 5'd0;
		if (id_on) begin
			frm = {frm[FRM_W-5:0], sid[`SID_FIELD_LSB+3:`SID_FIELD_LSB]};
			len = len + 5'd4;
		end
		if (kac_on) begin
			frm = {frm[FRM_W-3:0], kac_cur};
			len = len + 5'd2;
		end
		if (st_on) begin
			frm = {frm[FRM_W-5:0], code};
			len = len + 5'd4;
		end
		frm = {frm[FRM_W-DATA_W-1:0], (use_err ? err_code : meas)};
		len = len + DATA_W[4:0];
		frm = frm << (FRM_W[4:0] - len);
	end

	// an error seen even briefly is owed one frame; a new error wins over the clear
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			err_pend_r <= 1'b0;
		end else if (need_err) begin
			err_pend_r <= 1'b1;
		end else if (launch) begin
			err_pend_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// crc engine and sequencer
	// ---------------------------------------------------------------
	wire [7:0] crc;
	wire       calc_step = state_r[1];
	// message read in place, so the frame needs no restoring before sending
	wire       calc_bit  = (cnt_r < {1'b0, len_r}) ? shift_r[ALL_W-1-cnt_r] : 1'b0;

	crc8_serial #(
		.POLY   (`CRC_POLY)
	) u_crc (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.load_i (launch),
		.seed_i ({4'h0, sid[3:0]}),
		.step_i (calc_step),
		.din_i  (calc_bit),
		.crc_o  (crc)
	);

	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r     <= S_IDLE;
			src_r       <= 1'b0;
			shift_r     <= {ALL_W{1'b0}};
			len_r       <= 5'd0;
			cnt_r       <= 6'd0;
			send_cnt_r  <= 6'd0;
			kac_a_r     <= 2'b00;
			kac_b_r     <= 2'b00;
			last_code_r <= 4'h0;
			tx_bit_o    <= 1'b0;
			tx_valid_o  <= 1'b0;
			tx_last_o   <= 1'b0;
			busy_o      <= 1'b0;
		end else begin
			case (state_r)
			S_IDLE: begin
				if (launch) begin
					state_r     <= S_CALC;
					src_r       <= trigger_src_i;
					shift_r     <= {frm, 8'h00};
					len_r       <= len;
					cnt_r       <= 6'd0;
					last_code_r <= code;
					busy_o      <= 1'b1;
				end
			end
			S_CALC: begin
				// message bits then eight appended zeros
				cnt_r <= cnt_r + 6'd1;
				if (cnt_r == {1'b0, len_r} + 6'd7) begin
					state_r    <= S_SEND;
					send_cnt_r <= {1'b0, len_r} + 6'd8;
				end
			end
			S_SEND: begin
				if (!tx_valid_o) begin
					// crc goes right behind the last message bit, whatever the format
					shift_r    <= shift_r | ({{FRM_W{1'b0}}, crc} << (FRM_W[4:0] - len_r));
					tx_valid_o <= 1'b1;
					tx_bit_o   <= shift_r[ALL_W-1];
					tx_last_o  <= (send_cnt_r == 6'd1);
				end else if (tx_ready_i) begin
					send_cnt_r <= send_cnt_r - 6'd1;
					if (send_cnt_r == 6'd1) begin
						tx_valid_o <= 1'b0;
						tx_last_o  <= 1'b0;
						busy_o     <= 1'b0;
						state_r    <= S_IDLE;
						if (src_r)
							kac_b_r <= kac_b_r + 2'b01;
						else
							kac_a_r <= kac_a_r + 2'b01;
					end else begin
						shift_r   <= shift_r << 1;
						tx_bit_o  <= shift_r[ALL_W-2];
						tx_last_o <= (send_cnt_r == 6'd2);
					end
				end
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* dv/framer_sva.sv */
// concurrent checks on the framer ports
`timescale 1ns/1ps
`default_nettype none
module framer_sva (
	input wire logic        clk_i,
	input wire logic        rstn_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        trigger_i,
	input wire logic        tx_bit_o,
	input wire logic        tx_valid_o,
	input wire logic        tx_last_o,
	input wire logic        tx_ready_i,
	input wire logic        busy_o
);
	// ----------------------------------------
	// accepted bits of the frame in flight
	// ----------------------------------------
	logic [4:0] nbits_r;
	wire        acc = tx_valid_o && tx_ready_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			nbits_r <= 5'h00;
		else if (!busy_o)
			nbits_r <= 5'h00;
		else if (acc)
			nbits_r <= nbits_r + 5'h01;
	end
	AST_ONE_WAIT: assert property (psel_i && penable_i && !pready_o |=> pready_o)
		else $error("apb answer late");
	AST_READY_PULSE: assert property (pready_o |=> !pready_o)
		else $error("pready longer than one cycle");
	AST_IDLE_BUS: assert property (!pready_o |-> prdata_o == 32'h0 && !pslverr_o)
		else $error("read data or error outside answer");
	AST_VALID_IN_FRAME: assert property (tx_valid_o |-> busy_o)
		else $error("bit offered outside frame");
	AST_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_bit_o)
		&& $stable(tx_last_o))
		else $error("bit changed before accept");
	AST_END: assert property (acc && tx_last_o |=> !tx_valid_o && !busy_o)
		else $error("frame not closed after last bit");
	AST_LEN: assert property (acc && tx_last_o |-> nbits_r[0] && nbits_r >= 5'h11
		&& nbits_r <= 5'h1B)
		else $error("frame length off");
	AST_START: assert property (!busy_o && !trigger_i |=> !busy_o)
		else $error("frame without trigger");
	AST_CRC_TIME: assert property ($rose(busy_o) |-> !tx_valid_o [*8] ##[1:40] tx_valid_o)
		else $error("first bit timing off");
	cover property (acc && tx_last_o);
	cover property (pslverr_o);
	cover property (tx_valid_o && !tx_ready_i);
endmodule
bind periodic_response_framer framer_sva framer_sva_inst (.clk_i, .rstn_i, .psel_i,
	.penable_i, .prdata_o, .pready_o, .pslverr_o, .trigger_i, .tx_bit_o, .tx_valid_o,
	.tx_last_o, .tx_ready_i, .busy_o);
`default_nettype wire

/* dv/encoder_model.sv */
// symbol encoder stand-in that collects framer bits
`timescale 1ns/1ps
`default_nettype none
module encoder_model (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        tx_bit_i,
	input  wire logic        tx_valid_i,
	input  wire logic        tx_last_i,
	input  wire logic        slow_i,
	output wire logic        tx_ready_o,
	output var  logic        done_o,
	output var  logic [31:0] bits_o,
	output var  logic [5:0]  len_o
);
	logic [1:0]  cnt_r;
	logic [31:0] acc_r;
	logic [5:0]  n_r;
	// slow mode takes one bit in four, as a busy line driver would
	assign tx_ready_o = !slow_i || cnt_r == 2'h3;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_r <= 2'h0;
			acc_r <= 32'h0;
			n_r <= 6'h00;
			done_o <= 1'b0;
			bits_o <= 32'h0;
			len_o <= 6'h00;
		end else begin
			cnt_r <= cnt_r + 2'h1;
			done_o <= 1'b0;
			if (tx_valid_i && tx_ready_o) begin
				acc_r <= {acc_r[30:0], tx_bit_i};
				n_r <= n_r + 6'h01;
				if (tx_last_i) begin
					done_o <= 1'b1;
					bits_o <= {acc_r[30:0], tx_bit_i};
					len_o <= n_r + 6'h01;
					acc_r <= 32'h0;
					n_r <= 6'h00;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the periodic response framer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [47:0] CODES = 48'hDBA985444321;
	localparam logic [39:0] REGS  = 40'h7F201B1A01;
	localparam logic [39:0] RVAL  = 40'h0000727100;
	logic        clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0;
	logic        trigger_i = 1'b0;
	logic        trigger_src_i = 1'b0;
	logic [9:0]  meas_abs_i = 10'h000;
	logic [9:0]  meas_rel_i = 10'h000;
	logic [12:0] flt = 13'h0000;
	logic        slow = 1'b0;
	wire  [31:0] prdata_o;
	wire  [31:0] fr_bits;
	wire  [5:0]  fr_len;
	wire         pready_o, pslverr_o, tx_bit_o, tx_valid_o, tx_last_o;
	wire         tx_ready_i, busy_o, fr_done;
	logic [7:0]  sid [2];
	logic [7:0]  ctrl;
	logic [1:0]  keep_alive_count [2];
	logic [31:0] rs = 32'hFAE1;
	logic [37:0] exp_q [$];
	int          n_fail = 0;
	int          comparisons = 0;

	periodic_response_framer #(.SUP_HOLD_CYC(16'h0014)) periodic_response_framer_inst (
		.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
		.pready_o, .pslverr_o, .trigger_i, .trigger_src_i, .meas_abs_i, .meas_rel_i,
		.config_unlocked_i(flt[0]), .selftest_pending_i(flt[1]), .osc_train_fault_i(flt[2]),
		.abs_pressure_high_i(flt[3]), .abs_pressure_low_i(flt[4]),
		.abs_pressure_disagree_i(flt[5]), .temp_fault_i(flt[6]), .user_otp_fault_i(flt[7]),
		.user_rw_fault_i(flt[8]), .fact_otp_fault_i(flt[9]), .test_active_flag_i(flt[10]),
		.reset_occurred_flag_i(flt[11]), .supply_fault_i(flt[12]), .tx_bit_o, .tx_valid_o,
		.tx_last_o, .tx_ready_i, .busy_o);
	encoder_model encoder_model_inst (.clk_i, .rstn_i, .tx_bit_i(tx_bit_o),
		.tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o), .slow_i(slow),
		.tx_ready_o(tx_ready_i), .done_o(fr_done), .bits_o(fr_bits), .len_o(fr_len));

	initial forever #5 clk_i = ~clk_i;

	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	// ----------------------------------------
	// expected frame: length and bits, crc last
	// ----------------------------------------
	function automatic logic [37:0] mk(input logic [3:0] id, input logic [2:0] fm,
		input logic [1:0] ka, input logic [3:0] st, input logic [9:0] d);
		logic [31:0] v;
		logic [5:0]  n;
		logic [7:0]  c;
		logic        b;
		v = 32'h0;
		n = 6'h00;
		if (fm[0]) begin
			v = {v[27:0], id};
			n = n + 6'h04;
		end
		if (fm[1]) begin
			v = {v[29:0], ka};
			n = n + 6'h02;
		end
		if (fm[2]) begin
			v = {v[27:0], st};
			n = n + 6'h04;
		end
		v = {v[21:0], d};
		n = n + 6'h0A;
		c = {4'h0, id};
		for (int i = n + 7; i >= 0; i--) begin
			b = (i >= 8) ? v[i-8] : 1'b0;
			c = c[7] ? ({c[6:0], b} ^ 8'h2F) : {c[6:0], b};
		end
		return {n + 6'h08, v[23:0], c};
	endfunction

	task automatic fail(input string m);
		n_fail++;
		$display("ERROR %0t %s", $time, m);
	endtask

	task automatic chk_reg(input logic [32:0] got, input logic [32:0] exp);
		comparisons++;
		if (got !== exp)
			fail("register read mismatch");
	endtask

	task automatic chk_frame(input logic [37:0] exp);
		comparisons++;
		if ({fr_len, fr_bits} !== exp)
			fail("frame mismatch");
	endtask

	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [32:0] rd);
		int n;
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= {2'h0, idx, 2'h0};
		pwdata_i <= {24'h0, wd};
		@(posedge clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		if (n >= 20)
			fail("apb timeout");
		rd = {pslverr_o, prdata_o};
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [32:0] rd;
		apb(1'b1, idx, wd, rd);
	endtask

	task automatic fire(input logic s);
		int n;
		@(posedge clk_i);
		trigger_i <= 1'b1;
		trigger_src_i <= s;
		@(posedge clk_i);
		trigger_i <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (busy_o !== 1'b0 && n < 400);
		if (n >= 400)
			fail("frame timeout");
	endtask

	task automatic frame(input logic s, input logic [3:0] st, input logic err);
		logic [31:0] r;
		logic [9:0]  d;
		r = rnd();
		meas_abs_i <= r[9:0];
		meas_rel_i <= r[19:10];
		slow <= r[20];
		d = sid[s][7] ? r[19:10] : r[9:0];
		if (err)
			d = (ctrl[3:2] != 2'h0) ? 10'h200 : 10'h000;
		exp_q.push_back(mk(sid[s][3:0], sid[s][6:4], keep_alive_count[s], st, d));
		keep_alive_count[s] = keep_alive_count[s] + 2'h1;
		fire(s);
	endtask

	task automatic stop_test();
		if (exp_q.size() != 0)
			fail("frames missing");
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk_i) begin
		if (fr_done === 1'b1) begin
			if (exp_q.size() == 0)
				fail("unexpected frame");
			else
				chk_frame(exp_q.pop_front());
		end
	end

	initial begin
		#300000;
		fail("watchdog expired");
		stop_test();
	end

	initial begin
		logic [32:0] rd;
		sid[0] = 8'h71;
		sid[1] = 8'h72;
		ctrl = 8'h00;
		keep_alive_count[0] = 2'h0;
		keep_alive_count[1] = 2'h0;
		repeat (8) @(posedge clk_i);
		rstn_i <= 1'b1;
		wr(8'h01, 8'hFF);
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, REGS[8*i +: 8], 8'h00, rd);
			chk_reg(rd, {i == 4, 24'h0, RVAL[8*i +: 8]});
		end
		fire(1'b0);
		repeat (40) @(posedge clk_i);
		chk_reg({32'h0, busy_o}, 33'h0);
		$display("test registers and mode-off finished");
		wr(8'h20, 8'h01);
		ctrl = 8'h01;
		for (int i = 0; i < 5; i++)
			frame(i == 2, 4'h0, 1'b0);
		wr(8'h1B, 8'hF2);
		sid[1] = 8'hF2;
		frame(1'b1, 4'h0, 1'b0);
		$display("test normal frames finished");
		for (int i = 0; i < 12; i++) begin
			flt <= 13'h0001 << i;
			repeat (3) @(posedge clk_i);
			frame(i[0], CODES[4*i +: 4], i > 6);
			flt <= 13'h0000;
			repeat (3) @(posedge clk_i);
		end
		flt <= 13'h0148;
		repeat (3) @(posedge clk_i);
		frame(1'b0, 4'h9, 1'b1);
		flt <= 13'h0000;
		$display("test status codes finished");
		wr(8'h20, 8'h05);
		ctrl = 8'h05;
		flt <= 13'h1000;
		repeat (3) @(posedge clk_i);
		fire(1'b0);
		repeat (30) @(posedge clk_i);
		frame(1'b1, 4'hC, 1'b1);
		flt <= 13'h0000;
		wr(8'h1A, 8'h01);
		sid[0] = 8'h01;
		frame(1'b0, 4'h0, 1'b1);
		frame(1'b1, 4'h0, 1'b0);
		wr(8'h20, 8'h07);
		ctrl = 8'h07;
		flt <= 13'h1000;
		repeat (30) @(posedge clk_i);
		frame(1'b1, 4'h0, 1'b0);
		flt <= 13'h0000;
		repeat (3) @(posedge clk_i);
		flt <= 13'h0040;
		repeat (3) @(posedge clk_i);
		frame(1'b0, 4'h0, 1'b1);
		repeat (10) @(posedge clk_i);
		apb(1'b0, 8'h21, 8'h00, rd);
		chk_reg(rd, {25'h0, keep_alive_count[1], keep_alive_count[0], 4'h5});
		$display("test supply, signed and format finished");
		stop_test();
	end
endmodule
`default_nettype wire
